// File: rtl/cms_status.sv
// Mode and status bits of a CAN controller error-and-status word.
// Assumes a protocol engine that reports frame activity and obeys freeze.
//
// Overview of operation
// - Suspend acknowledge, bit 5, sets once suspended, one cycle to a frame.
// - While suspended the protocol engine is frozen: no receive or transmit.
// - Suspend requested mid-frame waits for that frame to end.
// - Debug suspend accepted only when soft-run bit 16 of control is zero.
// - Bit 4 shows configuration write grant, set one cycle after grant.
// - Configuration grant bit reads one after reset.
// - Once cleared, grant not set again until receive pin sampled high.
// - Bit 3 is one in power-down, zero in normal operation.
// - Bit 1 high while the engine is actually receiving a message.
// - Bit 0 high while the engine is actually transmitting a message.
// - Bit 2 reserved: writes ignored, value not to be relied on.
//
// Chosen here: the register addresses and strobed register access.
`default_nettype none
module cms_status
	import cms_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [cms_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cms_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [cms_pkg::DATA_W-1:0] reg_rdata,
	input wire logic debug_halt,
	input wire logic bus_receive_pin,
	input wire logic engine_rx_busy,
	input wire logic engine_tx_busy,
	input wire logic engine_frame_end,
	output logic engine_freeze,
	output logic config_write_grant,
	output logic powerdown_ack,
	output logic irq
);
	import cms_pkg::*;

	logic [DATA_W-1:0] master_control_reg;
	logic [EV_W-1:0] irq_stat;
	logic [EV_W-1:0] irq_mask;
	logic [EV_W-1:0] next_irq_stat;
	logic [EV_W-1:0] events;
	cms_susp_e susp_state;
	cms_susp_e next_susp_state;
	logic suspend_ack;
	logic receive_active;
	logic transmit_active;
	logic halt_sync;
	logic halt_meta;
	logic rx_pin_sync;
	logic rx_seen_high;
	logic frame_busy;
	logic suspend_req;
	logic cfg_req;
	logic cfg_grant_pending;
	logic prev_suspend_ack;
	logic prev_grant;
	logic prev_powerdown;

	function automatic logic is_write(input logic [ADDR_W-1:0] a);
		is_write = reg_write && (reg_addr == a);
	endfunction : is_write

	cms_sync u_rx_sync (
		.clock(clock),
		.rst_b(rst_b),
		.async_in(bus_receive_pin),
		.sync_out(rx_pin_sync)
	);

	// Debugger halt is another domain, double sampled
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			halt_meta <= 1'b0;
			halt_sync <= 1'b0;
		end else begin
			halt_meta <= debug_halt;
			halt_sync <= halt_meta;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			master_control_reg <= CONTROL_RESET;
		end else if (is_write(ADDR_CONTROL)) begin
			master_control_reg <= reg_wdata;
		end
	end

	assign suspend_req = halt_sync && !master_control_reg[BIT_SOFT_RUN]
		|| master_control_reg[BIT_SUSP_REQ]
		&& !master_control_reg[BIT_SOFT_RUN];
	assign frame_busy = engine_rx_busy || engine_tx_busy;

	always_comb begin
		next_susp_state = susp_state;
		unique case (susp_state)
			CMS_RUN: begin
				if (suspend_req) begin
					next_susp_state = frame_busy ? CMS_DRAIN : CMS_SUSP;
				end
			end
			CMS_DRAIN: begin
				if (!suspend_req) begin
					next_susp_state = CMS_RUN;
				end else if (engine_frame_end || !frame_busy) begin
					next_susp_state = CMS_SUSP;
				end
			end
			CMS_SUSP: begin
				if (!suspend_req) begin
					next_susp_state = CMS_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			susp_state <= CMS_RUN;
		end else begin
			susp_state <= next_susp_state;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			suspend_ack <= 1'b0;
		end else begin
			suspend_ack <= (next_susp_state == CMS_SUSP);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			engine_freeze <= 1'b0;
		end else begin
			engine_freeze <= (next_susp_state == CMS_SUSP);
		end
	end

	// Request clear or set of the configuration grant
	assign cfg_req = master_control_reg[BIT_CFG_REQ];

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rx_seen_high <= 1'b1;
		end else if (config_write_grant && !cfg_req) begin
			rx_seen_high <= 1'b0;
		end else if (rx_pin_sync) begin
			rx_seen_high <= 1'b1;
		end
	end

	// Grant is decided a cycle before it shows
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cfg_grant_pending <= 1'b1;
		end else begin
			cfg_grant_pending <= cfg_req && (config_write_grant || rx_seen_high);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			config_write_grant <= 1'b1;
		end else begin
			config_write_grant <= cfg_grant_pending;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			powerdown_ack <= 1'b0;
		end else begin
			powerdown_ack <= master_control_reg[BIT_PDN_REQ] && !frame_busy;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			receive_active <= 1'b0;
			transmit_active <= 1'b0;
		end else begin
			receive_active <= engine_rx_busy && !engine_freeze;
			transmit_active <= engine_tx_busy && !engine_freeze;
		end
	end

	// Rising edges of acknowledges become events
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			prev_suspend_ack <= 1'b0;
			prev_grant <= 1'b1;
			prev_powerdown <= 1'b0;
		end else begin
			prev_suspend_ack <= suspend_ack;
			prev_grant <= config_write_grant;
			prev_powerdown <= powerdown_ack;
		end
	end

	assign events = {powerdown_ack && !prev_powerdown,
		config_write_grant && !prev_grant,
		suspend_ack && !prev_suspend_ack};

	// Set wins over a write-one clear
	always_comb begin
		next_irq_stat = irq_stat;
		if (is_write(ADDR_IRQ_STAT)) begin
			next_irq_stat = irq_stat & ~reg_wdata[EV_W-1:0];
		end
		next_irq_stat = next_irq_stat | events;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			irq_stat <= EV_ZERO;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			irq_mask <= EV_ZERO;
		end else if (is_write(ADDR_IRQ_MASK)) begin
			irq_mask <= reg_wdata[EV_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_stat & irq_mask);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			reg_rdata <= WORD_ZERO;
		end else begin
			reg_rdata <= WORD_ZERO;
			if (reg_read) begin
				unique case (reg_addr)
					ADDR_STATUS: begin
						reg_rdata[BIT_SUSP_ACK] <= suspend_ack;
						reg_rdata[BIT_GRANT] <= config_write_grant;
						reg_rdata[BIT_PDN_ACK] <= powerdown_ack;
						reg_rdata[BIT_RSVD] <= 1'b0;
						reg_rdata[BIT_RX] <= receive_active;
						reg_rdata[BIT_TX] <= transmit_active;
					end
					ADDR_CONTROL: reg_rdata <= master_control_reg;
					ADDR_IRQ_STAT: reg_rdata[EV_W-1:0] <= irq_stat;
					ADDR_IRQ_MASK: reg_rdata[EV_W-1:0] <= irq_mask;
					default: reg_rdata <= WORD_ZERO;
				endcase
			end
		end
	end

	// Idle engine: acknowledge and freeze one cycle after the request
	property p_susp_ack;
		@(posedge clock) disable iff (!rst_b)
		(susp_state == CMS_RUN) && suspend_req && !frame_busy
			|=> suspend_ack && engine_freeze;
	endproperty
	a_susp_ack: assert property (p_susp_ack)
		else $error("suspend ack not set one cycle after request");

	property p_frozen_quiet;
		@(posedge clock) disable iff (!rst_b)
		engine_freeze |=> !receive_active && !transmit_active;
	endproperty
	a_frozen_quiet: assert property (p_frozen_quiet)
		else $error("activity shown while frozen");

	property p_no_mid_frame;
		@(posedge clock) disable iff (!rst_b)
		(susp_state == CMS_RUN) && frame_busy |=> !suspend_ack;
	endproperty
	a_no_mid_frame: assert property (p_no_mid_frame)
		else $error("suspended in mid frame");

	property p_soft_run;
		@(posedge clock) disable iff (!rst_b)
		master_control_reg[BIT_SOFT_RUN] && !suspend_ack |=> !suspend_ack;
	endproperty
	a_soft_run: assert property (p_soft_run)
		else $error("suspend entered in run mode");

	sequence s_grant_ready;
		cfg_grant_pending && !config_write_grant;
	endsequence
	property p_grant_delay;
		@(posedge clock) disable iff (!rst_b)
		s_grant_ready |=> config_write_grant;
	endproperty
	a_grant_delay: assert property (p_grant_delay)
		else $error("grant not shown one cycle later");

	property p_grant_reset;
		@(posedge clock)
		$rose(rst_b) |-> config_write_grant;
	endproperty
	a_grant_reset: assert property (p_grant_reset)
		else $error("grant not one after reset");

	property p_regrant_needs_rx;
		@(posedge clock) disable iff (!rst_b)
		!config_write_grant && !rx_seen_high ##1 !rx_pin_sync
			|=> !config_write_grant;
	endproperty
	a_regrant_needs_rx: assert property (p_regrant_needs_rx)
		else $error("grant set without receive pin high");

	property p_pda_normal;
		@(posedge clock) disable iff (!rst_b)
		!master_control_reg[BIT_PDN_REQ] |=> !powerdown_ack;
	endproperty
	a_pda_normal: assert property (p_pda_normal)
		else $error("power-down ack in normal operation");

	property p_rx_follow;
		@(posedge clock) disable iff (!rst_b)
		engine_rx_busy && !engine_freeze |=> receive_active;
	endproperty
	a_rx_follow: assert property (p_rx_follow)
		else $error("receive activity not shown");

	property p_tx_follow;
		@(posedge clock) disable iff (!rst_b)
		!engine_tx_busy |=> !transmit_active;
	endproperty
	a_tx_follow: assert property (p_tx_follow)
		else $error("transmit shown while idle");

	property p_rsvd_zero;
		@(posedge clock) disable iff (!rst_b)
		reg_read && reg_addr == ADDR_STATUS |=> !reg_rdata[BIT_RSVD];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved status bit not zero");
endmodule : cms_status
`default_nettype wire

// File: rtl/cms_pkg.sv
// Constants for the controller mode and status block.
// Assumes a single 10 MHz module clock and a plain register port.
`default_nettype none
package cms_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// Register word addresses
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
	// Status bit positions
	localparam int BIT_TX = 0;
	localparam int BIT_RX = 1;
	localparam int BIT_RSVD = 2;
	localparam int BIT_PDN_ACK = 3;
	localparam int BIT_GRANT = 4;
	localparam int BIT_SUSP_ACK = 5;
	// Control bit positions
	localparam int BIT_SOFT_RUN = 16;
	localparam int BIT_CFG_REQ = 0;
	localparam int BIT_PDN_REQ = 1;
	localparam int BIT_SUSP_REQ = 2;
	// Interrupt event positions
	localparam int EV_SUSP = 0;
	localparam int EV_GRANT = 1;
	localparam int EV_PDN = 2;
	localparam int EV_W = 3;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
	localparam logic [2:0] EV_ZERO = 3'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// Module clock figures
	localparam int CLOCK_HZ = 10_000_000;
	localparam int BIT_TIME_NS = 1000;
	localparam int CYCLES_PER_BIT = BIT_TIME_NS / (1_000_000_000 / CLOCK_HZ);
	// Longest frame in bits, including stuffing and interframe space
	localparam int FRAME_BITS = 160;
	localparam int FRAME_CYCLES = FRAME_BITS * CYCLES_PER_BIT;
	typedef enum logic [1:0] {CMS_RUN, CMS_DRAIN, CMS_SUSP} cms_susp_e;
endpackage : cms_pkg
`default_nettype wire

// File: rtl/cms_sync.sv
// Two flip-flop synchroniser for a level from a pin.
// Assumes the input is asynchronous to clock.
`default_nettype none
module cms_sync (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;
	// Recessive level reset value, bus idles high
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			stage1 <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : cms_sync
`default_nettype wire

// File: tb/cms_engine_model.sv
// Behavioural protocol engine and receive pin facing the status block.
// Assumes the bench asks for frames by one-cycle start pulses.
`default_nettype none
module cms_engine_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic engine_freeze,
	input wire logic start_rx,
	input wire logic start_tx,
	input wire logic dominant,
	output logic engine_rx_busy,
	output logic engine_tx_busy,
	output logic engine_frame_end,
	output logic bus_receive_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FRAME_LEN = 24;
	int left;
	// frozen engine starts nothing, running frame completes
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			left <= 0;
			engine_rx_busy <= 1'b0;
			engine_tx_busy <= 1'b0;
			engine_frame_end <= 1'b0;
		end else begin
			engine_frame_end <= (left == 1);
			if (left == 0 && !engine_freeze && (start_rx || start_tx)) begin
				left <= FRAME_LEN;
				engine_rx_busy <= start_rx;
				engine_tx_busy <= start_tx;
			end else if (left != 0) begin
				left <= left - 1;
			end
			if (left == 1) begin
				engine_rx_busy <= 1'b0;
				engine_tx_busy <= 1'b0;
			end
		end
	end
	// pin low while dominant, else toggles in frames, recessive when idle
	assign bus_receive_pin = dominant ? 1'b0 :
		((engine_rx_busy || engine_tx_busy) ? left[0] : 1'b1);
endmodule : cms_engine_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the mode and status block.
// Assumes the engine model and the design package are compiled first.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cms_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic debug_halt = 1'b0;
	logic start_rx = 1'b0;
	logic start_tx = 1'b0;
	logic dominant = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic rx_busy, tx_busy, frame_end, freeze, grant, pdn_ack, irq, pin;
	int error_cnt = 0;
	int checked = 0;
	always #50 clock = ~clock;
	cms_engine_model eng (.clock(clock), .rst_b(rst_b),
		.engine_freeze(freeze), .start_rx(start_rx), .start_tx(start_tx),
		.dominant(dominant), .engine_rx_busy(rx_busy),
		.engine_tx_busy(tx_busy), .engine_frame_end(frame_end),
		.bus_receive_pin(pin));
	cms_status dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .debug_halt(debug_halt),
		.bus_receive_pin(pin), .engine_rx_busy(rx_busy),
		.engine_tx_busy(tx_busy), .engine_frame_end(frame_end),
		.engine_freeze(freeze), .config_write_grant(grant),
		.powerdown_ack(pdn_ack), .irq(irq));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test
	task automatic check_word(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word
	task automatic check_bit(input string name, input logic exp,
		input logic got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask : check_bit
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		check_word($sformatf("reg %h", a), exp, reg_rdata);
	endtask : rd_chk
	task automatic frame(input logic rx);
		@(posedge clock);
		start_rx <= rx;
		start_tx <= !rx;
		@(posedge clock);
		start_rx <= 1'b0;
		start_tx <= 1'b0;
	endtask : frame
	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		finish_test();
	end
	initial begin
		cyc(5);
		rst_b <= 1'b1;
		#1;
		check_bit("grant", 1'b1, grant);
		rd_chk(ADDR_STATUS, 32'h0000_0010);
		rd_chk(ADDR_CONTROL, 32'h0000_0001);
		rd_chk(ADDR_IRQ_MASK, 32'h0000_0000);
		wr(ADDR_STATUS, 32'hFFFF_FFFF);
		rd_chk(ADDR_STATUS, 32'h0000_0010);
		wr(4'hF, 32'hFFFF_FFFF);
		rd_chk(4'hF, 32'h0000_0000);
		frame(1'b1);
		rd_chk(ADDR_STATUS, 32'h0000_0012);
		cyc(30);
		frame(1'b0);
		rd_chk(ADDR_STATUS, 32'h0000_0011);
		// Suspend asked mid-frame waits for the frame end
		wr(ADDR_IRQ_MASK, 32'h0000_0001);
		wr(ADDR_CONTROL, 32'h0000_0005);
		rd_chk(ADDR_STATUS, 32'h0000_0011);
		check_bit("freeze", 1'b0, freeze);
		cyc(30);
		rd_chk(ADDR_STATUS, 32'h0000_0030);
		check_bit("freeze", 1'b1, freeze);
		check_bit("irq", 1'b1, irq);
		frame(1'b1);
		rd_chk(ADDR_STATUS, 32'h0000_0030);
		rd_chk(ADDR_IRQ_STAT, 32'h0000_0001);
		wr(ADDR_IRQ_STAT, 32'h0000_0001);
		rd_chk(ADDR_IRQ_STAT, 32'h0000_0000);
		check_bit("irq", 1'b0, irq);
		wr(ADDR_CONTROL, 32'h0000_0001);
		cyc(3);
		#1;
		check_bit("freeze", 1'b0, freeze);
		// Debug halt refused in run mode, taken once run mode ends
		@(posedge clock);
		debug_halt <= 1'b1;
		wr(ADDR_CONTROL, 32'h0001_0001);
		cyc(6);
		rd_chk(ADDR_STATUS, 32'h0000_0010);
		wr(ADDR_CONTROL, 32'h0000_0001);
		cyc(3);
		rd_chk(ADDR_STATUS, 32'h0000_0030);
		@(posedge clock);
		debug_halt <= 1'b0;
		cyc(6);
		rd_chk(ADDR_STATUS, 32'h0000_0010);
		wr(ADDR_IRQ_STAT, 32'h0000_0007);
		// Grant comes back only after the pin is seen high
		@(posedge clock);
		dominant <= 1'b1;
		cyc(4);
		wr(ADDR_CONTROL, 32'h0000_0000);
		cyc(3);
		rd_chk(ADDR_STATUS, 32'h0000_0000);
		wr(ADDR_CONTROL, 32'h0000_0001);
		cyc(10);
		#1;
		check_bit("grant", 1'b0, grant);
		@(posedge clock);
		dominant <= 1'b0;
		cyc(5);
		#1;
		check_bit("grant", 1'b1, grant);
		rd_chk(ADDR_IRQ_STAT, 32'h0000_0002);
		check_bit("irq", 1'b0, irq);
		wr(ADDR_IRQ_STAT, 32'h0000_0002);
		rd_chk(ADDR_IRQ_STAT, 32'h0000_0000);
		// Power-down waits for the running frame
		frame(1'b1);
		wr(ADDR_CONTROL, 32'h0000_0003);
		cyc(3);
		#1;
		check_bit("powerdown_ack", 1'b0, pdn_ack);
		cyc(30);
		#1;
		check_bit("powerdown_ack", 1'b1, pdn_ack);
		rd_chk(ADDR_STATUS, 32'h0000_0018);
		wr(ADDR_IRQ_MASK, 32'h0000_0004);
		rd_chk(ADDR_IRQ_STAT, 32'h0000_0004);
		check_bit("irq", 1'b1, irq);
		wr(ADDR_CONTROL, 32'h0000_0001);
		cyc(3);
		#1;
		check_bit("powerdown_ack", 1'b0, pdn_ack);
		rd_chk(ADDR_STATUS, 32'h0000_0010);
		finish_test();
	end
endmodule : tb
`default_nettype wire
